// >>> hw/spims_pkg.sv
// Constants and carrier types for the SPI master/slave port
// Summary of operation
// R1: Master data write starts eight-bit shift
// R2: Master stops clock, sets done flag
// R3: Done flag with enable raises interrupt
// R4: Software drives slave select in master
// R5: Next write starts next byte
// R6: Received byte copied into receive buffer
// R7: Slave deselected keeps MISO tri-stated
// R8: Deselected slave accepts writes, shifts nothing
// R9: Slave sets flag; tx reload anytime
// R10: Software waits for shift completion
// R11: Receive buffer holds byte during next
// R12: External clock phases exceed two cycles
// R13: Enabled role forces pin directions
// R14: MOSI carries master data, MISO slave
// R15: Master frames packets with slave select
// R16: Power-reduce bit disables the block
// R17: Bit order LSB or MSB first
// R18: Seven master rates including CK/2
// R19: Rising slave select resets slave shifter
// R20: Select low in master forces slave
// R21: Polarity and phase choose four modes
// R22: Data read returns receive buffer
package spims_pkg;
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [6:0] HALF_DIV2 = 7'h01;
    localparam logic [6:0] HALF_STEP = 7'h01;

    typedef struct packed {
        logic transfer_irq_enable;
        logic enable;
        logic lsb_first;
        logic master;
        logic cpol;
        logic cpha;
        logic [1:0] rate;
        logic dbl;
    } spims_ctrl_s;

    localparam spims_ctrl_s CTRL_RESET = '0;

    typedef struct packed {
        logic mosi_out;
        logic miso_out;
        logic sck_out;
        logic ss_out;
        logic ss_level;
    } spims_dir_s;

    typedef enum logic {M_IDLE, M_SHIFT} spims_mst_e;

    // Half SCK period in system clocks; rate 3 doubled equals rate 2, leaving seven rates
    function automatic logic [6:0] spims_half(input logic [1:0] rate, input logic dbl);
        logic [6:0] h;
        h = HALF_DIV4;
        case (rate)
            2'h0: h = HALF_DIV4;
            2'h1: h = HALF_DIV16;
            2'h2: h = HALF_DIV64;
            default: h = HALF_DIV128;
        endcase
        return dbl ? h >> 1 : h;
    endfunction : spims_half

    function automatic logic [7:0] spims_shift_in(input logic [7:0] v, input logic b,
        input logic lsb);
        return lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : spims_shift_in
endpackage : spims_pkg

// >>> hw/spims_port.sv
// SPI port: master shifter on clk_sys, slave shifter on the link clock
`timescale 1ns/10ps

module spims_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // A change is taken only once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                q <= s3_q;
        end
    end
endmodule : spims_sync3

module spims_port (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_link,
    input spims_pkg::spims_ctrl_s serial_control_reg,
    input wire logic ctrl_wr,
    input wire logic serial_power_reduce,
    input spims_pkg::spims_dir_s dir_i,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    output logic [7:0] serial_data_reg_rdata,
    input wire logic done_clr,
    output logic transfer_done_flag,
    output logic master_active,
    output logic busy,
    output logic transfer_irq,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    output logic sck_o,
    output logic sck_oe,
    input wire logic ss_i,
    output logic ss_o,
    output logic ss_oe
);
    import spims_pkg::*;

    spims_ctrl_s ctl_q;
    spims_mst_e mst_q;
    logic [6:0] div_q;
    logic [6:0] half_w;
    logic [3:0] edge_q;
    logic sck_q;
    logic [7:0] sh_q;
    logic samp_q;
    logic [7:0] tx_q;
    logic [7:0] rx_buf_q;
    logic flag_q;
    logic active;
    logic run_master;
    logic half_tick;
    logic sample_edge;
    logic master_done;
    logic [7:0] master_byte;
    logic ss_f;
    logic mode_fault;
    logic link_off_q;
    logic link_rst_q;
    logic link_arst;
    logic link_clk;
    logic [2:0] in_cnt_q;
    logic [7:0] in_sh_q;
    logic [7:0] rx_link_q;
    logic tgl_link_q;
    logic tgl_f;
    logic tgl_seen_q;
    logic slave_done;
    logic [2:0] out_cnt_q;
    logic [2:0] out_idx;

    assign active = ctl_q.enable & ~serial_power_reduce; // R16
    assign run_master = active & ctl_q.master;
    assign half_w = spims_half(ctl_q.rate, ctl_q.dbl); // R18
    assign half_tick = (mst_q == M_SHIFT) && (div_q == half_w - HALF_STEP);
    assign master_done = half_tick && (edge_q == LAST_EDGE);
    // Even edges lead; CPHA moves sampling to the trailing edge
    assign sample_edge = ~edge_q[0] ^ ctl_q.cpha; // R21
    assign master_byte = spims_shift_in(sh_q, ctl_q.cpha ? miso_i : samp_q,
        ctl_q.lsb_first);

    spims_sync3 #(
        .RST_VAL(1'b1)
    ) u_ss_sync (
        .clk(clk_sys),
        .rst_b(rst_b),
        .d(ss_i),
        .q(ss_f)
    );

    assign mode_fault = run_master && !dir_i.ss_out && !ss_f; // R20

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            ctl_q <= CTRL_RESET;
        else if (ctrl_wr)
            ctl_q <= serial_control_reg;
        else if (mode_fault)
            ctl_q.master <= 1'b0; // R20
    end

    // Master clock generator: sixteen SCK edges per byte, then stop
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            mst_q <= M_IDLE;
            div_q <= '0;
            edge_q <= '0;
            sck_q <= 1'b0;
        end
        else if (!run_master || mode_fault)
        begin
            mst_q <= M_IDLE;
            div_q <= '0;
            edge_q <= '0;
            sck_q <= ctl_q.cpol;
        end
        else
        begin
            case (mst_q)
                M_IDLE:
                begin
                    sck_q <= ctl_q.cpol;
                    div_q <= '0;
                    edge_q <= '0;
                    if (data_wr)
                        mst_q <= M_SHIFT; // R1 R5
                end
                M_SHIFT:
                begin
                    if (half_tick)
                    begin
                        div_q <= '0;
                        sck_q <= ~sck_q;
                        edge_q <= edge_q + 4'h1;
                        if (edge_q == LAST_EDGE)
                            mst_q <= M_IDLE; // R2
                    end
                    else
                        div_q <= div_q + HALF_STEP;
                end
                default: mst_q <= M_IDLE;
            endcase
        end
    end

    // Master shifter: sample on one edge, shift on the opposite one
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sh_q <= BYTE_RESET;
            samp_q <= 1'b0;
        end
        else if (mst_q == M_IDLE && data_wr && run_master)
            sh_q <= data_wdata; // R1
        else if (half_tick)
        begin
            if (sample_edge)
                samp_q <= miso_i; // R21
            else if (edge_q != 4'h0)
                sh_q <= spims_shift_in(sh_q, samp_q, ctl_q.lsb_first); // R17
        end
    end

    // Single transmit byte; a master write during a shift is dropped
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            tx_q <= BYTE_RESET;
        else if (data_wr && !(ctl_q.master && mst_q == M_SHIFT))
            tx_q <= data_wdata; // R8 R9
    end

    // Link shifter and counters are held in reset while the slave role is off
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            link_off_q <= 1'b1;
            link_rst_q <= 1'b1;
        end
        else
        begin
            link_off_q <= !(active && !ctl_q.master);
            link_rst_q <= 1'b0;
        end
    end

    // Modes 1 and 2 sample on falling SCK, so invert to sample on one edge
    assign link_clk = clk_link ^ (ctl_q.cpol ^ ctl_q.cpha); // R21
    assign link_arst = ss_i | link_off_q;

    // Select high clears the shifter at once and drops a partial byte
    always_ff @(posedge link_clk or posedge link_arst)
    begin
        if (link_arst)
        begin
            in_cnt_q <= '0; // R19 R8
            in_sh_q <= BYTE_RESET;
        end
        else
        begin
            in_cnt_q <= in_cnt_q + 3'h1;
            in_sh_q <= spims_shift_in(in_sh_q, mosi_i, ctl_q.lsb_first); // R14
        end
    end

    // Completed byte is held here for eight SCK cycles, long enough to cross
    always_ff @(posedge link_clk or posedge link_rst_q)
    begin
        if (link_rst_q)
        begin
            rx_link_q <= BYTE_RESET;
            tgl_link_q <= 1'b0;
        end
        else if (in_cnt_q == LAST_BIT)
        begin
            rx_link_q <= spims_shift_in(in_sh_q, mosi_i, ctl_q.lsb_first);
            tgl_link_q <= ~tgl_link_q;
        end
    end

    always_ff @(negedge link_clk or posedge link_arst)
    begin
        if (link_arst)
            out_cnt_q <= '0;
        else
            out_cnt_q <= out_cnt_q + 3'h1;
    end

    // With CPHA set the first setup edge presents bit zero
    assign out_idx = out_cnt_q - {2'h0, ctl_q.cpha};

    spims_sync3 #(
        .RST_VAL(1'b0)
    ) u_done_sync (
        .clk(clk_sys),
        .rst_b(rst_b),
        .d(tgl_link_q),
        .q(tgl_f)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            tgl_seen_q <= 1'b0;
        else
            tgl_seen_q <= tgl_f;
    end

    assign slave_done = (tgl_f != tgl_seen_q);

    // Receive buffer: only a finished byte overwrites it
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            rx_buf_q <= BYTE_RESET;
        else if (master_done)
            rx_buf_q <= master_byte; // R6 R11
        else if (slave_done)
            rx_buf_q <= rx_link_q; // R6 R11
    end

    // Setting wins over a clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            flag_q <= 1'b0;
        else if (master_done || slave_done || mode_fault)
            flag_q <= 1'b1; // R2 R9 R20
        else if (done_clr)
            flag_q <= 1'b0;
    end

    assign serial_data_reg_rdata = rx_buf_q; // R22
    assign transfer_done_flag = flag_q;
    assign transfer_irq = flag_q & ctl_q.transfer_irq_enable; // R3
    assign master_active = ctl_q.master;
    assign busy = (mst_q == M_SHIFT);

    assign sck_o = sck_q;
    assign mosi_o = ctl_q.lsb_first ? sh_q[0] : sh_q[7]; // R14
    assign miso_o = ctl_q.lsb_first ? tx_q[out_idx] : tx_q[LAST_BIT - out_idx];
    assign ss_o = dir_i.ss_level; // R4
    assign mosi_oe = run_master & dir_i.mosi_out; // R13
    assign sck_oe = run_master & dir_i.sck_out; // R13
    assign ss_oe = run_master & dir_i.ss_out; // R13
    assign miso_oe = active & ~ctl_q.master & dir_i.miso_out & ~ss_i; // R7 R13

    sequence s_start;
        mst_q == M_IDLE && data_wr && run_master && !mode_fault;
    endsequence

    sequence s_fast_start;
        s_start ##0 half_w == HALF_DIV2;
    endsequence

    a_master_start: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
        s_start |=> busy && sck_o == ctl_q.cpol && sh_q == $past(data_wdata))
        else $error("master write did not start a byte");

    a_byte_length: assert property (@(posedge clk_sys) // R2
        disable iff (!rst_b || !run_master)
        s_fast_start |-> ##16 master_done)
        else $error("fast byte did not end after sixteen edges");

    a_clock_halt: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
        master_done |=> !busy && sck_o == ctl_q.cpol && transfer_done_flag)
        else $error("clock not stopped or flag not set after byte");

    a_irq_raise: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
        (slave_done || master_done) && ctl_q.transfer_irq_enable |=> transfer_irq)
        else $error("interrupt not raised on completed byte");

    a_rx_capture: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
        slave_done && !master_done |=> serial_data_reg_rdata == $past(rx_link_q))
        else $error("slave byte not copied to receive buffer");

    a_rx_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
        !master_done && !slave_done |=> $stable(serial_data_reg_rdata))
        else $error("receive buffer changed without a finished byte");

    a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2 R9
        (slave_done || master_done) && done_clr |=> transfer_done_flag)
        else $error("clear overrode a completed byte");

    a_mode_fault: assert property (@(posedge clk_sys) disable iff (!rst_b) // R20
        mode_fault && !ctrl_wr |=> !master_active && transfer_done_flag && !busy)
        else $error("select low did not force slave role");

    a_slave_pins: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
        active && !ctl_q.master |-> !mosi_oe && !sck_oe && !ss_oe)
        else $error("slave drove an input-only pin");

    a_master_miso: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
        ctl_q.master || ss_f |-> !miso_oe || !ss_i)
        else $error("MISO driven while not selected");
endmodule : spims_port

// >>> dv/spims_far_model.sv
// Far-side SPI device: a slave answering the port, or a master driving it
`timescale 1ns/10ps

module spims_far_model (
    input wire logic clk_base,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    input wire logic [7:0] tx,
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    input wire logic ss_w,
    output logic sck_drv,
    output logic mosi_drv,
    output logic miso_drv,
    output logic ss_drv,
    output logic [7:0] rx
);
    logic [3:0] k = 4'h0;
    logic mst = 1'b0;

    initial
    begin
        {sck_drv, mosi_drv, miso_drv, ss_drv} = 4'h1;
        rx = 8'h00;
    end

    function automatic logic pick(input logic [7:0] b, input logic [3:0] i);
        return lsb ? b[i[2:0]] : b[3'h7 - i[2:0]];
    endfunction : pick

    function automatic logic [7:0] shin(input logic [7:0] v, input logic b);
        return lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shin

    always @(negedge ss_w)
        if (!mst)
        begin
            k = 4'h0;
            miso_drv = pick(tx, 4'h0);
        end

    // Released line shows the inverse so a stale value never passes as data
    always @(posedge ss_w)
        if (!mst)
            miso_drv = ~miso_drv;

    always @(sck_w)
        if (!mst && ss_w === 1'b0)
        begin
            if (sck_w == (cpol ~^ cpha))
            begin
                rx = shin(rx, mosi_w);
                k = k + 4'h1;
            end
            else
                miso_drv = pick(tx, k);
        end

    // SCK runs only inside a run call, and select drops only when sel is set; each phase lasts three base ticks
    task automatic run(input logic [7:0] b, input int nbits, input logic sel);
        mst = 1'b1;
        sck_drv = cpol;
        mosi_drv = pick(b, 4'h0);
        @(posedge clk_base);
        ss_drv = ~sel;
        repeat (3) @(posedge clk_base);
        for (int i = 0; i < nbits; i++)
        begin
            if (!cpha)
                rx = shin(rx, miso_w);
            else
                mosi_drv = pick(b, 4'(i));
            sck_drv = ~cpol;
            repeat (3) @(posedge clk_base);
            if (cpha)
                rx = shin(rx, miso_w);
            else
                mosi_drv = pick(b, 4'(i + 1));
            sck_drv = cpol;
            repeat (3) @(posedge clk_base);
        end
        ss_drv = 1'b1;
        mosi_drv = ~mosi_drv;
        repeat (3) @(posedge clk_base);
        mst = 1'b0;
    endtask : run
endmodule : spims_far_model

// >>> dv/spims_port_tb.sv
// Self-checking bench for the SPI master/slave port
`timescale 1ns/10ps

module spims_port_tb;
    import spims_pkg::*;
    logic clk_sys, clk_base, rst_b, ctrl_wr, pr, data_wr, done_clr, ss_tb;
    spims_ctrl_s ctrl;
    spims_dir_s dir;
    logic [7:0] wdata, rdata, frx, ftx;
    logic flag, mact, busy, irq, mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_o, ss_oe;
    logic sck_d, mosi_d, miso_d, ss_d, fpol, fpha, flsb;
    wire sck_w = sck_oe ? sck_o : sck_d;
    wire mosi_w = mosi_oe ? mosi_o : mosi_d;
    wire miso_w = miso_oe ? miso_o : miso_d;
    wire ss_w = ss_oe ? ss_o : (ss_d & ss_tb);
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int half_tb[4] = '{2, 8, 32, 64};

    spims_port DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_link(sck_w),
        .serial_control_reg(ctrl), .ctrl_wr(ctrl_wr), .serial_power_reduce(pr),
        .dir_i(dir), .data_wr(data_wr), .data_wdata(wdata),
        .serial_data_reg_rdata(rdata), .done_clr(done_clr), .transfer_done_flag(flag),
        .master_active(mact), .busy(busy), .transfer_irq(irq),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
        .sck_o(sck_o), .sck_oe(sck_oe), .ss_i(ss_w), .ss_o(ss_o), .ss_oe(ss_oe)
    );

    spims_far_model far (
        .clk_base(clk_base), .cpol(fpol), .cpha(fpha), .lsb(flsb), .tx(ftx),
        .sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .ss_w(ss_w),
        .sck_drv(sck_d), .mosi_drv(mosi_d), .miso_drv(miso_d), .ss_drv(ss_d), .rx(frx)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial
    begin
        clk_base = 1'b0;
        #3;
        forever #6 clk_base = ~clk_base;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic cfg(input spims_ctrl_s c, input spims_dir_s d);
        ctrl = c;
        dir = d;
        {fpol, fpha, flsb} = {c.cpol, c.cpha, c.lsb_first};
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wr = 1'b0;
        tick(2);
    endtask : cfg

    task automatic wr(input logic [7:0] b);
        data_wr = 1'b1;
        wdata = b;
        tick(1);
        data_wr = 1'b0;
    endtask : wr

    task automatic clr();
        done_clr = 1'b1;
        tick(1);
        done_clr = 1'b0;
        tick(1);
    endtask : clr

    task automatic wait_idle(output int n);
        n = 0;
        while (busy === 1'b1 && n < 3000)
        begin
            tick(1);
            n++;
        end
    endtask : wait_idle

    task automatic wait_flag();
        int n = 0;
        while (flag !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
    endtask : wait_flag

    task automatic t_master();
        spims_ctrl_s c;
        logic [7:0] b;
        int n;
        // Seven rates; modes and bit order cycle through the loop index
        for (int i = 0; i < 7; i++)
        begin
            c = '{1'b1, 1'b1, i[2], 1'b1, i[1], i[0], 2'(i % 4), i > 3};
            b = 8'h96 + 8'(i) * 8'h11;
            ftx = ~b;
            cfg(c, '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1});
            dir.ss_level = 1'b0;
            tick(2);
            check({mosi_oe, sck_oe, ss_oe}, 3'h7);
            check(miso_oe, 1'b0);
            wr(b);
            check(busy, 1'b1);
            wait_idle(n);
            check(16'(n), 16'(16 * (half_tb[i % 4] >> (i > 3))));
            check(flag, 1'b1);
            check(irq, 1'b1);
            check(rdata, ftx);
            check(frx, b);
            clr();
            dir.ss_level = 1'b1;
            tick(2);
        end
        $display("test master done");
    endtask : t_master

    task automatic t_master_misc();
        int n;
        ftx = 8'h5e;
        cfg('{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1}, '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1});
        dir.ss_level = 1'b0;
        tick(2);
        wr(8'h11);
        tick(3);
        wr(8'h22);
        wait_idle(n);
        check(frx, 8'h11);
        clr();
        wr(8'h33);
        // Clear lands on the edge that ends the byte; the set must win
        tick(15);
        done_clr = 1'b1;
        tick(1);
        done_clr = 1'b0;
        check(flag, 1'b1);
        wait_idle(n);
        check(frx, 8'h33);
        check(rdata, 8'h5e);
        check(irq, 1'b0);
        clr();
        pr = 1'b1;
        wr(8'h44);
        tick(1);
        check(busy, 1'b0);
        pr = 1'b0;
        // Select as input pulled low by another master
        cfg(ctrl, '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1});
        ss_tb = 1'b0;
        tick(8);
        check(mact, 1'b0);
        check(flag, 1'b1);
        ss_tb = 1'b1;
        clr();
        $display("test master misc done");
    endtask : t_master_misc

    task automatic t_slave();
        spims_ctrl_s c;
        for (int i = 0; i < 4; i++)
        begin
            c = '{i[0], 1'b1, i[1], 1'b0, i[1], i[0], 2'h0, 1'b0};
            cfg(c, '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1});
            check(miso_oe, 1'b0);
            check({sck_oe, mosi_oe}, 2'h0);
            wr(8'h3c + 8'(i));
            far.run(8'hff, 8, 1'b0);
            tick(8);
            check(flag, 1'b0);
            far.run(8'h0f, 5, 1'b1);
            far.run(8'hc5 - 8'(i), 8, 1'b1);
            wait_flag();
            check(flag, 1'b1);
            check(rdata, 8'hc5 - 8'(i));
            check(frx, 8'h3c + 8'(i));
            check(irq, i[0]);
            clr();
        end
        far.run(8'h5a, 8, 1'b1);
        wait_flag();
        check(rdata, 8'h5a);
        clr();
        far.run(8'h24, 5, 1'b1);
        check(rdata, 8'h5a);
        far.run(8'h81, 8, 1'b1);
        wait_flag();
        check(rdata, 8'h81);
        $display("test slave done");
    endtask : t_slave

    initial
    begin
        {rst_b, ctrl_wr, pr, data_wr, done_clr, fpol, fpha, flsb} = '0;
        ss_tb = 1'b1;
        ctrl = '0;
        dir = '0;
        wdata = 8'h00;
        ftx = 8'h00;
        tick(12);
        rst_b = 1'b1;
        check({flag, mact, busy, irq, mosi_oe, miso_oe, sck_oe, ss_oe}, 8'h00);
        check(rdata, 8'h00);
        $display("test reset done");
        t_master();
        t_master_misc();
        t_slave();
        summarize();
    end
endmodule : spims_port_tb
